// >>> logic/fpi_flash_array.sv
// Purpose: Flash byte array with clear-only write and byte erase
// Assumes: One access per cycle, registered read data
// Notes:   Array contents have no reset, as flash keeps its data
`timescale 1ns/1ps
module fpi_flash_array
    import fpi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic              er_en,
    input  wire logic [FL_AW-1:0]  addr,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata
);

    logic [7:0] mem [0:(1<<FL_AW)-1];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (er_en) begin
            mem[addr] <= ERASED_BYTE;
        end else if (wr_en) begin
            mem[addr] <= mem[addr] & wdata;
        end
        rdata <= mem[addr];
    end

endmodule : fpi_flash_array

// >>> logic/fpi_flash_prog.sv
// Purpose: Boot functions and low-level flash programming over AHB-Lite
// Assumes: Single word transfers, response always OKAY
// Notes:   Internal-execution writes stall the bus and hold interrupts
`timescale 1ns/1ps
module fpi_flash_prog
    import fpi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             programming_busy_flag,
    output logic             cpu_stall,
    output logic             irq_hold,
    output logic             double_speed_fuse,
    output logic             bootloader_jump_fuse
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]         expanded_data_ram [0:(1<<EXPANDED_DATA_RAM_AW)-1];
    logic               wr_pend_r, wr_pend_nxt;
    logic [7:0]         addr_r, addr_nxt;
    logic [31:0]        hrdata_r, hrdata_nxt;
    logic               accept;
    logic               wr_now;
    logic [7:0]         sel_r, sel_nxt;
    logic [7:0]         acc_r, acc_nxt;
    logic [15:0]        dptr_r, dptr_nxt;
    logic [15:0]        src_r, src_nxt;
    logic               ext_r, ext_nxt;
    logic               err_r, err_nxt;
    logic [EXPANDED_DATA_RAM_AW-1:0] xaddr_r, xaddr_nxt;
    logic               x2_r, x2_nxt;
    logic               blj_r, blj_nxt;
    fpi_state_t         st_r, st_nxt;
    logic [TMR_W-1:0]   tmr_r, tmr_nxt;
    logic [CNT_W-1:0]   cnt_r, cnt_nxt;
    logic [FL_AW-1:0]   fa_r, fa_nxt;
    logic [15:0]        fs_r, fs_nxt;
    logic [PAGE_AW:0]   eidx_r, eidx_nxt;
    logic               page_op_r, page_op_nxt;
    logic               fl_wr, fl_er;
    logic [FL_AW-1:0]   fl_addr;
    logic [7:0]         fl_wdata;
    logic [7:0]         fl_rdata;
    logic               busy;
    logic               expanded_data_ram_we;
    logic               do_call, do_fwrite, do_ferase;

    assign busy = (st_r != FPI_IDLE);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    assign hreadyout = !(busy && !ext_r);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign accept    = hsel && htrans[1] && hready;
    assign wr_now    = wr_pend_r && hreadyout;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            OFF_SELECTOR:   v[7:0]  = sel_r;
            OFF_ACC:        v[7:0]  = acc_r;
            OFF_DPTR:       v[15:0] = dptr_r;
            OFF_SRC_PTR:    v[15:0] = src_r;
            OFF_CALL:       v[0]    = busy;
            OFF_FLASH_CTRL: v[FC_BUSY_BIT] = busy;
            OFF_DMEM_CTRL: begin
                v[DM_EXT_BIT] = ext_r;
                v[DM_ERR_BIT] = err_r;
            end
            OFF_EXPANDED_DATA_RAM_ADDR:  v[EXPANDED_DATA_RAM_AW-1:0] = xaddr_r;
            OFF_EXPANDED_DATA_RAM_DATA:  v[7:0]  = expanded_data_ram[xaddr_r];
            OFF_FLASH_RD:   v[7:0]  = fl_rdata;
            OFF_CFG_BYTES: begin
                v[CFG_X2_BIT]  = x2_r;
                v[CFG_BLJ_BIT] = blj_r;
            end
            default:        v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd_mux

    always_comb begin
        wr_pend_nxt = wr_pend_r;
        addr_nxt    = addr_r;
        if (hreadyout) begin
            wr_pend_nxt = accept && hwrite;
            if (accept) begin
                addr_nxt = haddr[7:0];
            end
        end
        hrdata_nxt = rd_mux(accept ? haddr[7:0] : addr_r);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            addr_r    <= addr_nxt;
            hrdata_r  <= hrdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    assign do_call   = wr_now && (addr_r == OFF_CALL) && hwdata[0] && !busy;
    assign do_fwrite = wr_now && (addr_r == OFF_FLASH_CTRL)
                       && hwdata[FC_WRITE_BIT] && !busy;
    assign do_ferase = wr_now && (addr_r == OFF_FLASH_CTRL)
                       && hwdata[FC_ERASE_BIT] && !hwdata[FC_WRITE_BIT] && !busy;
    assign expanded_data_ram_we   = wr_now && (addr_r == OFF_EXPANDED_DATA_RAM_DATA);

    always_ff @(posedge clk) begin
        if (expanded_data_ram_we) begin
            expanded_data_ram[xaddr_r] <= hwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Boot functions and programming sequencer
    // ----------------------------------------------------------------
    always_comb begin
        sel_nxt     = sel_r;
        acc_nxt     = acc_r;
        dptr_nxt    = dptr_r;
        src_nxt     = src_r;
        ext_nxt     = ext_r;
        err_nxt     = err_r;
        xaddr_nxt   = xaddr_r;
        x2_nxt      = x2_r;
        blj_nxt     = blj_r;
        st_nxt      = st_r;
        tmr_nxt     = tmr_r;
        cnt_nxt     = cnt_r;
        fa_nxt      = fa_r;
        fs_nxt      = fs_r;
        eidx_nxt    = eidx_r;
        page_op_nxt = page_op_r;
        fl_wr       = 1'b0;
        fl_er       = 1'b0;
        fl_addr     = dptr_r;
        fl_wdata    = acc_r;
        if (wr_now && !busy) begin
            unique case (addr_r)
                OFF_SELECTOR:  sel_nxt  = hwdata[7:0];
                OFF_ACC:       acc_nxt  = hwdata[7:0];
                OFF_DPTR:      dptr_nxt = hwdata[15:0];
                OFF_SRC_PTR:   src_nxt  = hwdata[15:0];
                OFF_DMEM_CTRL: begin
                    ext_nxt = hwdata[DM_EXT_BIT];
                    if (hwdata[DM_ERR_BIT]) begin
                        err_nxt = 1'b0;
                    end
                end
                OFF_EXPANDED_DATA_RAM_ADDR: xaddr_nxt = hwdata[EXPANDED_DATA_RAM_AW-1:0];
                default: ;
            endcase
        end
        if (expanded_data_ram_we) begin
            xaddr_nxt = xaddr_r + 1'b1;
        end
        if (do_call) begin
            unique case (sel_r)
                SEL_READ_CFG: begin
                    if (dptr_r == DP_SSB) begin
                        acc_nxt = RST_SSB;
                    end else if (dptr_r == DP_BSB) begin
                        acc_nxt = RST_BSB;
                    end else if (dptr_r == DP_SBV) begin
                        acc_nxt = RST_SBV;
                    end
                end
                SEL_PROG_PAGE: begin
                    // Page write: stalls the CPU unless external execution (ext_r) is set
                    if (acc_r != 8'h00) begin
                        page_op_nxt = 1'b1;
                        cnt_nxt     = acc_r;
                        fa_nxt      = dptr_r;
                        fs_nxt      = src_r;
                        st_nxt      = FPI_SRC;
                    end
                end
                SEL_PROG_FUSE: begin
                    if (acc_r[7:1] != 7'h00) begin
                        err_nxt = 1'b1;
                    end else if (dptr_r == DP_X2_FUSE) begin
                        x2_nxt  = acc_r[0];
                        cnt_nxt = 8'h01;
                        tmr_nxt = TMR_W'(BYTE_PROG_CYC);
                        st_nxt  = FPI_WAIT;
                    end else if (dptr_r == DP_BLJ_FUSE) begin
                        blj_nxt = acc_r[0];
                        cnt_nxt = 8'h01;
                        tmr_nxt = TMR_W'(BYTE_PROG_CYC);
                        st_nxt  = FPI_WAIT;
                    end
                end
                SEL_READ_HSB: acc_nxt = RST_HSB;
                SEL_READ_VER: acc_nxt = BOOT_VERSION;
                default: ;
            endcase
        end
        if (do_fwrite) begin
            fl_wr       = 1'b1;
            page_op_nxt = 1'b0;
            cnt_nxt     = 8'h01;
            tmr_nxt     = TMR_W'(BYTE_PROG_CYC);
            st_nxt      = FPI_WAIT;
        end
        if (do_ferase) begin
            page_op_nxt = 1'b0;
            fa_nxt      = {dptr_r[FL_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
            eidx_nxt    = '0;
            st_nxt      = FPI_ERASE;
        end
        unique case (st_r)
            FPI_IDLE: ;
            FPI_SRC: begin
                fl_wr    = 1'b1;
                fl_addr  = fa_r;
                fl_wdata = expanded_data_ram[fs_r[EXPANDED_DATA_RAM_AW-1:0]];
                tmr_nxt  = TMR_W'(BYTE_PROG_CYC);
                st_nxt   = FPI_WAIT;
            end
            FPI_ERASE: begin
                fl_er   = 1'b1;
                fl_addr = fa_r | FL_AW'(eidx_r[PAGE_AW-1:0]);
                if (eidx_r == (PAGE_AW+1)'(PAGE_BYTES - 1)) begin
                    cnt_nxt = 8'h01;
                    tmr_nxt = TMR_W'(PAGE_ERASE_CYC);
                    st_nxt  = FPI_WAIT;
                end else begin
                    eidx_nxt = eidx_r + 1'b1;
                end
            end
            FPI_WAIT: begin
                if (tmr_r > TMR_W'(1)) begin
                    tmr_nxt = tmr_r - 1'b1;
                end else if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 1'b1;
                    fa_nxt  = fa_r + 1'b1;
                    fs_nxt  = fs_r + 1'b1;
                    st_nxt  = FPI_SRC;
                end else begin
                    cnt_nxt = 8'h00;
                    if (page_op_r) begin
                        acc_nxt = 8'h00;
                    end
                    page_op_nxt = 1'b0;
                    st_nxt      = FPI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_r     <= 8'h00;
            acc_r     <= 8'h00;
            dptr_r    <= 16'h0000;
            src_r     <= 16'h0000;
            ext_r     <= 1'b0;
            err_r     <= 1'b0;
            xaddr_r   <= '0;
            x2_r      <= 1'b0;
            blj_r     <= 1'b0;
            st_r      <= FPI_IDLE;
            tmr_r     <= '0;
            cnt_r     <= '0;
            fa_r      <= '0;
            fs_r      <= 16'h0000;
            eidx_r    <= '0;
            page_op_r <= 1'b0;
        end else begin
            sel_r     <= sel_nxt;
            acc_r     <= acc_nxt;
            dptr_r    <= dptr_nxt;
            src_r     <= src_nxt;
            ext_r     <= ext_nxt;
            err_r     <= err_nxt;
            xaddr_r   <= xaddr_nxt;
            x2_r      <= x2_nxt;
            blj_r     <= blj_nxt;
            st_r      <= st_nxt;
            tmr_r     <= tmr_nxt;
            cnt_r     <= cnt_nxt;
            fa_r      <= fa_nxt;
            fs_r      <= fs_nxt;
            eidx_r    <= eidx_nxt;
            page_op_r <= page_op_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Flash array and status outputs
    // ----------------------------------------------------------------
    fpi_flash_array u_array (
        .clk   (clk),
        .wr_en (fl_wr),
        .er_en (fl_er),
        .addr  (fl_addr),
        .wdata (fl_wdata),
        .rdata (fl_rdata)
    );

    assign programming_busy_flag = busy;
    assign cpu_stall             = busy && !ext_r;
    assign irq_hold              = busy && !ext_r;
    assign double_speed_fuse     = x2_r;
    assign bootloader_jump_fuse  = blj_r;

endmodule : fpi_flash_prog

// >>> logic/fpi_pkg.sv
// Purpose: Constants for the flash program interface
// Assumes: 25 MHz clock, AHB-Lite register access, 32-bit words
// Notes:   Register offsets are byte addresses
package fpi_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ        = 25;
    localparam int          BYTE_PROG_NS   = 1000;
    localparam int          PAGE_ERASE_NS  = 4000;
    localparam int          BYTE_PROG_CYC  = (BYTE_PROG_NS * CLK_MHZ + 999) / 1000;
    localparam int          PAGE_ERASE_CYC = (PAGE_ERASE_NS * CLK_MHZ + 999) / 1000;
    localparam int          TMR_W          = 8;

    // ----------------------------------------------------------------
    // Memory geometry
    // ----------------------------------------------------------------
    localparam int          FL_AW          = 16;
    localparam int          PAGE_BYTES     = 128;
    localparam int          PAGE_AW        = 7;
    localparam int          EXPANDED_DATA_RAM_AW        = 8;
    localparam int          CNT_W          = 8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFF_SELECTOR   = 8'h00;
    localparam logic [7:0]  OFF_ACC        = 8'h04;
    localparam logic [7:0]  OFF_DPTR       = 8'h08;
    localparam logic [7:0]  OFF_SRC_PTR    = 8'h0C;
    localparam logic [7:0]  OFF_CALL       = 8'h10;
    localparam logic [7:0]  OFF_FLASH_CTRL = 8'h14;
    localparam logic [7:0]  OFF_DMEM_CTRL  = 8'h18;
    localparam logic [7:0]  OFF_EXPANDED_DATA_RAM_ADDR  = 8'h1C;
    localparam logic [7:0]  OFF_EXPANDED_DATA_RAM_DATA  = 8'h20;
    localparam logic [7:0]  OFF_FLASH_RD   = 8'h24;
    localparam logic [7:0]  OFF_CFG_BYTES  = 8'h28;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          FC_BUSY_BIT    = 0;
    localparam int          FC_WRITE_BIT   = 1;
    localparam int          FC_ERASE_BIT   = 2;
    localparam int          DM_EXT_BIT     = 0;
    localparam int          DM_ERR_BIT     = 1;
    localparam int          CFG_X2_BIT     = 0;
    localparam int          CFG_BLJ_BIT    = 1;

    // ----------------------------------------------------------------
    // Boot function selectors and pointer codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  SEL_READ_CFG   = 8'h07;
    localparam logic [7:0]  SEL_PROG_PAGE  = 8'h09;
    localparam logic [7:0]  SEL_PROG_FUSE  = 8'h0A;
    localparam logic [7:0]  SEL_READ_HSB   = 8'h0B;
    localparam logic [7:0]  SEL_READ_VER   = 8'h0F;
    localparam logic [15:0] DP_SSB         = 16'h0000;
    localparam logic [15:0] DP_BSB         = 16'h0001;
    localparam logic [15:0] DP_SBV         = 16'h0002;
    localparam logic [15:0] DP_X2_FUSE     = 16'h0008;
    localparam logic [15:0] DP_BLJ_FUSE    = 16'h0004;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_SSB        = 8'hFF;
    localparam logic [7:0]  RST_BSB        = 8'hFF;
    localparam logic [7:0]  RST_SBV        = 8'hFF;
    localparam logic [7:0]  RST_HSB        = 8'hFF;
    localparam logic [7:0]  BOOT_VERSION   = 8'h01;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    typedef enum logic [1:0] {
        FPI_IDLE,
        FPI_SRC,
        FPI_ERASE,
        FPI_WAIT
    } fpi_state_t;

endpackage : fpi_pkg

// >>> sim/fpi_cpu_model.sv
// Purpose: Bus master standing in for the CPU core
// Assumes: Single word transfers, one slave, hready = hreadyout
// Notes:   Signals change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module fpi_cpu_model (
    input  wire logic        clk,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    // ----------------------------------------------------------------
    // Idle bus; interrupts stay off, code stays in boot space
    // ----------------------------------------------------------------
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // ----------------------------------------------------------------
    // One transfer: address phase, then data phase
    // ----------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : xfer
endmodule : fpi_cpu_model

// >>> sim/fpi_flash_prog_properties.sv
// Purpose: Port checker for the flash program interface
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by bind below
`timescale 1ns/1ps
module fpi_flash_prog_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        programming_busy_flag,
    input wire logic        cpu_stall,
    input wire logic        irq_hold,
    input wire logic        double_speed_fuse,
    input wire logic        bootloader_jump_fuse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [11:0] busy_cnt;
    always_ff @(posedge clk) begin
        if (rst || !programming_busy_flag) busy_cnt <= 12'h0;
        else busy_cnt <= busy_cnt + 12'h1;
    end
    sequence s_busy_end;
        programming_busy_flag ##1 !programming_busy_flag;
    endsequence
    property p_stall_busy; cpu_stall |-> programming_busy_flag; endproperty
    a_stall_busy: assert property (p_stall_busy) else $error("stall without busy");
    property p_stall_wait; cpu_stall |-> !hreadyout; endproperty
    a_stall_wait: assert property (p_stall_wait) else $error("bus runs in stall");
    property p_irq; irq_hold == (programming_busy_flag && !hreadyout); endproperty
    a_irq: assert property (p_irq) else $error("interrupt hold mismatch");
    property p_ext_run; programming_busy_flag && !cpu_stall |-> hreadyout; endproperty
    a_ext_run: assert property (p_ext_run) else $error("external run stalled");
    property p_idle_ready; !programming_busy_flag |-> hreadyout && !hresp; endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("idle bus not ready");
    property p_busy_len; busy_cnt < 12'hD48; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_end_free; s_busy_end |-> hreadyout && !irq_hold; endproperty
    a_end_free: assert property (p_end_free) else $error("hold after busy");
    property p_x2_fuse;
        $changed(double_speed_fuse) |-> $past(programming_busy_flag) || programming_busy_flag;
    endproperty
    a_x2_fuse: assert property (p_x2_fuse) else $error("fuse moved while idle");
    property p_blj_fuse;
        $changed(bootloader_jump_fuse) |-> $past(programming_busy_flag) || programming_busy_flag;
    endproperty
    a_blj_fuse: assert property (p_blj_fuse) else $error("fuse moved while idle");
endmodule : fpi_flash_prog_checker

bind fpi_flash_prog fpi_flash_prog_checker i_chk (.clk(clk), .rst(rst), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .programming_busy_flag(programming_busy_flag),
    .cpu_stall(cpu_stall), .irq_hold(irq_hold), .double_speed_fuse(double_speed_fuse),
    .bootloader_jump_fuse(bootloader_jump_fuse));

// >>> sim/fpi_flash_prog_tb_top.sv
// Purpose: Self-checking bench for the flash program interface
// Assumes: External execution except in the stall scenario
// Notes:   Flash contents modelled in an integer array
`timescale 1ns/1ps
module fpi_flash_prog_tb_top
    import fpi_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, hsel, hwrite, hreadyout, hresp, busy, stall, irqh, x2, blj;
    logic [31:0] haddr, hwdata, hrdata, q, r, seed = 32'h23;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] p;
    int n_fail = 0, checked = 0, cyc = 0, t0;
    int fl [int];
    int xd [$];
    always #20 clk = ~clk;
    fpi_cpu_model i_cpu (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
    fpi_flash_prog i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .programming_busy_flag(busy),
        .cpu_stall(stall), .irq_hold(irqh), .double_speed_fuse(x2),
        .bootloader_jump_fuse(blj));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic stop_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        i_cpu.xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_cpu.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic poll(input logic [7:0] a);
        q = 32'h1;
        while (q[0] !== 1'b0) rd(a);
    endtask : poll
    task automatic call(input logic [7:0] s, input logic [15:0] dp, input logic [7:0] a);
        wr(OFF_SELECTOR, {24'h0, s});
        wr(OFF_DPTR, {16'h0, dp});
        wr(OFF_ACC, {24'h0, a});
        wr(OFF_CALL, 32'h1);
    endtask : call
    task automatic rf(input logic [7:0] s, input logic [15:0] dp, input logic [7:0] e);
        call(s, dp, 8'h5A);
        rd(OFF_ACC);
        chk(q, {24'h0, e});
    endtask : rf
    task automatic frd(input logic [15:0] a);
        wr(OFF_DPTR, {16'h0, a});
        repeat (2) @(posedge clk);
        rd(OFF_FLASH_RD);
        chk(q, fl[a]);
    endtask : frd
    task automatic fwr(input logic [15:0] a, input logic [7:0] d);
        wr(OFF_ACC, {24'h0, d});
        wr(OFF_DPTR, {16'h0, a});
        wr(OFF_FLASH_CTRL, 32'h2);
        fl[a] = fl[a] & d;
    endtask : fwr
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CFG_BYTES);
        chk(q, 32'h0);
        rd(8'hF0);
        chk(q, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wr(OFF_DMEM_CTRL, 32'h1);
        rf(SEL_READ_CFG, DP_SSB, RST_SSB);
        rf(SEL_READ_CFG, DP_BSB, RST_BSB);
        rf(SEL_READ_CFG, DP_SBV, RST_SBV);
        rf(SEL_READ_HSB, 16'(rnd()), RST_HSB);
        rf(SEL_READ_VER, 16'(rnd()), BOOT_VERSION);
        call(SEL_PROG_FUSE, DP_X2_FUSE, 8'h01);
        poll(OFF_CALL);
        chk({30'h0, blj, x2}, 32'h1);
        call(SEL_PROG_FUSE, DP_BLJ_FUSE, 8'h01);
        poll(OFF_CALL);
        call(SEL_PROG_FUSE, DP_X2_FUSE, 8'h00);
        poll(OFF_CALL);
        call(8'h33, DP_X2_FUSE, 8'h01);
        poll(OFF_CALL);
        rd(OFF_CFG_BYTES);
        chk(q, 32'h2);
        r = rnd();
        p = {r[15:7], 7'h00};
        wr(OFF_DPTR, {16'h0, p});
        wr(OFF_FLASH_CTRL, 32'h4);
        for (int i = 0; i < PAGE_BYTES; i++) fl[p + i] = 32'hFF;
        rd(OFF_FLASH_CTRL);
        chk({31'h0, q[0]}, 32'h1);
        chk({31'h0, busy}, 32'h1);
        poll(OFF_FLASH_CTRL);
        frd(p);
        frd(p + 16'h7F);
        fwr(p + 16'h5, 8'(rnd()));
        poll(OFF_FLASH_CTRL);
        fwr(p + 16'h5, 8'(rnd()));
        poll(OFF_FLASH_CTRL);
        frd(p + 16'h5);
        wr(OFF_EXPANDED_DATA_RAM_ADDR, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xd.push_back(rnd() & 32'hFF);
            wr(OFF_EXPANDED_DATA_RAM_DATA, xd[i]);
            fl[p + 16'h10 + i] = fl[p + 16'h10 + i] & xd[i];
        end
        wr(OFF_SRC_PTR, 32'h0);
        call(SEL_PROG_PAGE, p + 16'h10, 8'h04);
        poll(OFF_CALL);
        rd(OFF_ACC);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++) frd(16'(p + 16'h10 + i));
        wr(OFF_DMEM_CTRL, 32'h0);
        fwr(p + 16'h5, 8'h00);
        t0 = cyc;
        #1;
        chk({30'h0, irqh, stall}, 32'h3);
        rd(OFF_FLASH_CTRL);
        chk({31'h0, q[0]}, 32'h0);
        chk(32'(cyc - t0 >= BYTE_PROG_CYC), 32'h1);
        frd(p + 16'h5);
        stop_test();
    end
endmodule : fpi_flash_prog_tb_top
